// ===== verilog/clc_pkg.sv
`default_nettype none
package clc_pkg;
	// ----------------------------------------
	// array dimensions
	// ----------------------------------------
	localparam int N_IN       = 62;          // plane inputs
	localparam int N_LIT      = 2 * N_IN;    // true plus inverted literals
	localparam int N_PT       = 124;         // product terms in the plane
	localparam int N_GRP      = 2;           // sum groups
	localparam int N_GRP_PT   = 60;          // product terms owned by one group
	localparam int N_GRP_CELL = 12;          // cells served by one group
	localparam int N_CELL     = N_GRP * N_GRP_CELL;
	localparam int N_SUM      = 4;           // sum functions per cell

	// ----------------------------------------
	// sum function indices inside a cell
	// ----------------------------------------
	localparam int SUM_A = 0;
	localparam int SUM_B = 1;
	localparam int SUM_C = 2;
	localparam int SUM_D = 3;

	// ----------------------------------------
	// product terms kept for the global cell
	// ----------------------------------------
	localparam int PT_GLB_PRESET = 120;      // global preset term
	localparam int PT_GLB_RESET  = 121;      // global reset term
	localparam int PT_GLB_TYPE   = 122;      // run-time register type term

	// ----------------------------------------
	// per-cell configuration codes
	// ----------------------------------------
	localparam logic [1:0] REG_D  = 2'h0;    // d flip-flop
	localparam logic [1:0] REG_T  = 2'h1;    // toggle flip-flop
	localparam logic [1:0] REG_JK = 2'h2;    // jk, clocked sr as subset

	localparam logic [1:0] CLK_GLB  = 2'h0;  // global fast clock
	localparam logic [1:0] CLK_SUMC = 2'h1;  // third sum as clock
	localparam logic [1:0] CLK_SUMD = 2'h2;  // fourth sum as clock

	localparam logic [1:0] OUT_Q    = 2'h0;  // registered output
	localparam logic [1:0] OUT_SUMA = 2'h1;  // first sum path
	localparam logic [1:0] OUT_SUMB = 2'h2;  // second sum path
	localparam logic [1:0] OUT_SUMC = 2'h3;  // third sum path
endpackage
`default_nettype wire

// ===== verilog/clc_array.sv
`default_nettype none
// What this block does
// - plane takes 62 synchronised array inputs
// - each input offered true and inverted
// - 124 product terms, shareable among sums
// - four sums per cell; terms feed globals
// - two groups, 12 cells, 60 terms each
// - cell takes four sums, four outputs
// - register is D, T or JK
// - first sum is D/T/J or path
// - second sum is K, preset or path
// - third sum is clock, reset or path
// - fourth sum is clock, enable or feedback
// - global controls reach every cell
// - global clock polarity, global preset, reset
// - global term switches D and T
// - two outputs pick register or sum path
// - cell outputs operate independently
module clc_array (
	input  wire logic                                         sys_clk_in,      // system clock
	input  wire logic                                         rst_in,          // async reset
	input  wire logic [clc_pkg::N_IN-1:0]                     array_in,        // array pins
	input  wire logic                                         glb_clk_in,      // global clock pin
	input  wire logic                                         glb_clk_pol_in,  // 1 inverts it
	input  wire logic [clc_pkg::N_PT*clc_pkg::N_LIT-1:0]      and_plane_in,    // and fuses
	input  wire logic [clc_pkg::N_CELL*clc_pkg::N_SUM*clc_pkg::N_GRP_PT-1:0] or_plane_in,
	input  wire logic [2*clc_pkg::N_CELL-1:0]                 reg_type_in,     // type code
	input  wire logic [2*clc_pkg::N_CELL-1:0]                 clk_sel_in,      // clock source
	input  wire logic [clc_pkg::N_CELL-1:0]                   clk_pol_in,      // cell polarity
	input  wire logic [clc_pkg::N_CELL-1:0]                   preset_en_in,    // sum b presets
	input  wire logic [clc_pkg::N_CELL-1:0]                   reset_en_in,     // sum c resets
	input  wire logic [clc_pkg::N_CELL-1:0]                   async_ctl_in,    // async set/clr
	input  wire logic [clc_pkg::N_CELL-1:0]                   type_sw_en_in,   // global d/t
	input  wire logic [2*clc_pkg::N_CELL-1:0]                 out_a_sel_in,    // output a mux
	input  wire logic [2*clc_pkg::N_CELL-1:0]                 out_b_sel_in,    // output b mux
	output logic      [clc_pkg::N_CELL-1:0]                   out_a_out,       // first output
	output logic      [clc_pkg::N_CELL-1:0]                   out_b_out,       // second output
	output logic      [clc_pkg::N_CELL-1:0]                   oe_out,          // io cell enable
	output logic      [clc_pkg::N_CELL-1:0]                   fb_out           // buried feedback
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [clc_pkg::N_IN-1:0]   s1;     // first sync stage
		logic [clc_pkg::N_IN-1:0]   s2;     // second sync stage
		logic [clc_pkg::N_IN-1:0]   s3;     // third sync stage
		logic [clc_pkg::N_IN-1:0]   filt;   // agreed input value
		logic                       g_s1;   // global clock sync
		logic                       g_s2;
		logic                       g_s3;
		logic                       g_filt;
		logic [clc_pkg::N_CELL-1:0] q;      // cell registers
		logic [clc_pkg::N_CELL-1:0] prev;   // last clock level per cell
		logic [clc_pkg::N_CELL-1:0] out_a;
		logic [clc_pkg::N_CELL-1:0] out_b;
		logic [clc_pkg::N_CELL-1:0] oe;
		logic [clc_pkg::N_CELL-1:0] fb;
		logic                       live;   // low only in the first cycle out of reset
	} clc_state_t;

	clc_state_t r_reg;   // registered state
	clc_state_t r_next;  // next state

	logic [clc_pkg::N_PT-1:0]                    pt_vec;     // product terms
	logic [clc_pkg::N_CELL-1:0][clc_pkg::N_SUM-1:0] sum_plane; // sums per cell
	logic [clc_pkg::N_CELL-1:0]                  clk_rise;   // cell clock edges
	logic                                        glb_pre;    // global preset
	logic                                        glb_rst;    // global reset
	logic                                        glb_type;   // high selects toggle
	logic                                        glb_clk;    // polarised global clock

	// ----------------------------------------
	// plane helpers
	// ----------------------------------------
	// a term with no fuses counts as unused and reads low, so an
	// unprogrammed global term never resets the whole array
	function automatic logic clc_pt_eval(input logic [clc_pkg::N_LIT-1:0] fuse,
		input logic [clc_pkg::N_LIT-1:0] lits);
		clc_pt_eval = (|fuse) & (&(~fuse | lits));
	endfunction

	// or of the connected terms of one group
	function automatic logic clc_sum_eval(input logic [clc_pkg::N_GRP_PT-1:0] fuse,
		input logic [clc_pkg::N_GRP_PT-1:0] terms);
		clc_sum_eval = |(fuse & terms);
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [clc_pkg::N_LIT-1:0]    lits;
		logic [clc_pkg::N_GRP_PT-1:0] grp_pts;
		logic [1:0]                   typ;
		logic [1:0]                   csel;
		logic                         sa;
		logic                         sb;
		logic                         sc;
		logic                         sd;
		logic                         src;
		logic                         lvl;
		logic                         k_in;
		logic                         c_rst;
		logic                         c_pre;
		logic                         d_in;
		logic                         qn;
		lits    = '0;
		grp_pts = '0;
		typ     = clc_pkg::REG_D;
		csel    = clc_pkg::CLK_GLB;
		sa      = 1'b0;
		sb      = 1'b0;
		sc      = 1'b0;
		sd      = 1'b0;
		src     = 1'b0;
		lvl     = 1'b0;
		k_in    = 1'b0;
		c_rst   = 1'b0;
		c_pre   = 1'b0;
		d_in    = 1'b0;
		qn      = 1'b0;
		r_next  = r_reg;
		pt_vec  = '0;
		sum_plane = '0;
		clk_rise  = '0;
		// edge detection starts one cycle after reset
		r_next.live = 1'b1;

		r_next.s1     = array_in;
		r_next.s2     = r_reg.s1;
		r_next.s3     = r_reg.s2;
		// a bit moves only once stages two and three agree
		r_next.filt   = (r_reg.s2 & r_reg.s3) | (r_reg.filt & (r_reg.s2 ^ r_reg.s3));
		r_next.g_s1   = glb_clk_in;
		r_next.g_s2   = r_reg.g_s1;
		r_next.g_s3   = r_reg.g_s2;
		if (r_reg.g_s2 == r_reg.g_s3) begin
			r_next.g_filt = r_reg.g_s3;
		end

		lits = {~r_reg.filt, r_reg.filt};

		for (int p = 0; p < clc_pkg::N_PT; p++) begin
			pt_vec[p] = clc_pt_eval(and_plane_in[p*clc_pkg::N_LIT +: clc_pkg::N_LIT], lits);
		end

		// global cell fed from reserved terms
		glb_pre  = pt_vec[clc_pkg::PT_GLB_PRESET];
		glb_rst  = pt_vec[clc_pkg::PT_GLB_RESET];
		glb_type = pt_vec[clc_pkg::PT_GLB_TYPE];
		glb_clk  = r_reg.g_filt ^ glb_clk_pol_in;

		for (int c = 0; c < clc_pkg::N_CELL; c++) begin
			// each group owns its own block of 60 terms
			grp_pts = pt_vec[(c / clc_pkg::N_GRP_CELL) * clc_pkg::N_GRP_PT +: clc_pkg::N_GRP_PT];
			for (int s = 0; s < clc_pkg::N_SUM; s++) begin
				sum_plane[c][s] = clc_sum_eval(
					or_plane_in[(c*clc_pkg::N_SUM + s)*clc_pkg::N_GRP_PT +: clc_pkg::N_GRP_PT],
					grp_pts);
			end
			// the four sums of this cell
			sa   = sum_plane[c][clc_pkg::SUM_A];
			sb   = sum_plane[c][clc_pkg::SUM_B];
			sc   = sum_plane[c][clc_pkg::SUM_C];
			sd   = sum_plane[c][clc_pkg::SUM_D];
			csel = clk_sel_in[2*c +: 2];

			case (csel)
				clc_pkg::CLK_SUMC: begin
					src = sc;
				end
				clc_pkg::CLK_SUMD: begin
					src = sd;
				end
				default: begin
					src = glb_clk;
				end
			endcase
			// sum clocks are sampled and filtered, so they must stay at or below a quarter of the system rate
			lvl            = src ^ clk_pol_in[c];
			// prev clears low, so a source idling high would look like a rise
			// straight after reset; the live bit masks that first cycle
			clk_rise[c]    = lvl & ~r_reg.prev[c] & r_reg.live;
			r_next.prev[c] = lvl;

			// second sum is preset or K
			c_pre = preset_en_in[c] & sb;
			k_in  = preset_en_in[c] ? 1'b0 : sb;
			// third sum as reset unless it clocks
			c_rst = reset_en_in[c] & sc & (csel != clc_pkg::CLK_SUMC);

			if (type_sw_en_in[c]) begin
				typ = glb_type ? clc_pkg::REG_T : clc_pkg::REG_D;
			end else begin
				typ = reg_type_in[2*c +: 2];
			end

			// first sum drives D, T or J
			case (typ)
				clc_pkg::REG_D: begin
					d_in = sa;
				end
				clc_pkg::REG_T: begin
					d_in = r_reg.q[c] ^ sa;
				end
				clc_pkg::REG_JK: begin
					d_in = (sa & ~r_reg.q[c]) | (~k_in & r_reg.q[c]);
				end
				default: begin
					d_in = r_reg.q[c];
				end
			endcase

			qn = r_reg.q[c];
			if (clk_rise[c]) begin
				if (glb_rst | (c_rst & ~async_ctl_in[c])) begin
					qn = 1'b0;
				end else if (glb_pre | (c_pre & ~async_ctl_in[c])) begin
					qn = 1'b1;
				end else begin
					qn = d_in;
				end
			end
			// asynchronous controls act without waiting for a clock edge
			if (async_ctl_in[c]) begin
				// reset wins, a global reset on this edge too
				if (c_rst) begin
					qn = 1'b0;
				end else if (c_pre & ~(clk_rise[c] & glb_rst)) begin
					qn = 1'b1;
				end
			end
			r_next.q[c] = qn;

			case (out_a_sel_in[2*c +: 2])
				clc_pkg::OUT_SUMA: r_next.out_a[c] = sa;
				clc_pkg::OUT_SUMB: r_next.out_a[c] = sb;
				clc_pkg::OUT_SUMC: r_next.out_a[c] = sc;
				default:           r_next.out_a[c] = qn;
			endcase
			case (out_b_sel_in[2*c +: 2])
				clc_pkg::OUT_SUMA: r_next.out_b[c] = sa;
				clc_pkg::OUT_SUMB: r_next.out_b[c] = sb;
				clc_pkg::OUT_SUMC: r_next.out_b[c] = sc;
				default:           r_next.out_b[c] = qn;
			endcase
			// enable follows fourth sum; held on when it clocks
			r_next.oe[c] = (csel == clc_pkg::CLK_SUMD) ? 1'b1 : sd;
			r_next.fb[c] = sd;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from flip-flops
	assign out_a_out = r_reg.out_a;
	assign out_b_out = r_reg.out_b;
	assign oe_out    = r_reg.oe;
	assign fb_out    = r_reg.fb;

	// ----------------------------------------
	// checks on the cells the bench configures
	// ----------------------------------------
	default clocking clc_cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	sync_filter_a: assert property (
		(r_reg.s2[0] == r_reg.s3[0]) |=> (r_reg.filt[0] == $past(r_reg.s3[0])))
		else $error("filtered input did not follow agreeing stages");

	reset_wins_a: assert property (
		(async_ctl_in[3] && reset_en_in[3] && preset_en_in[3] && sum_plane[3][clc_pkg::SUM_C]
		&& sum_plane[3][clc_pkg::SUM_B] && clk_sel_in[7:6] != clc_pkg::CLK_SUMC)
		|=> !r_reg.q[3])
		else $error("preset overrode reset");

	d_load_a: assert property (
		(clk_rise[0] && !type_sw_en_in[0] && reg_type_in[1:0] == clc_pkg::REG_D
		&& !glb_rst && !glb_pre && !reset_en_in[0] && !preset_en_in[0])
		|=> (r_reg.q[0] == $past(sum_plane[0][0])))
		else $error("d register did not load first sum");

	t_count_a: assert property (
		(clk_rise[4] && type_sw_en_in[4] && glb_type && sum_plane[4][clc_pkg::SUM_A]
		&& !glb_rst && !glb_pre && !reset_en_in[4] && !preset_en_in[4])
		|=> (r_reg.q[4] != $past(r_reg.q[4])))
		else $error("counting type did not toggle");

	glb_reset_a: assert property (
		(clk_rise[0] && glb_rst) |=> !r_reg.q[0])
		else $error("global reset ignored on clock edge");

	hold_q_a: assert property (
		(!clk_rise[0] && !async_ctl_in[0]) |=> $stable(r_reg.q[0]))
		else $error("cell register changed without a clock edge");

	out_path_a: assert property (
		(out_a_sel_in[1:0] == clc_pkg::OUT_SUMA)
		|=> (out_a_out[0] == $past(sum_plane[0][clc_pkg::SUM_A])))
		else $error("output a did not carry first sum");

	out_reg_a: assert property (
		(out_b_sel_in[3:2] == clc_pkg::OUT_Q) |=> (out_b_out[1] == r_reg.q[1]))
		else $error("output b did not carry register");

	oe_path_a: assert property (
		(clk_sel_in[1:0] != clc_pkg::CLK_SUMD) |=> (oe_out[0] == $past(sum_plane[0][3])))
		else $error("enable did not follow fourth sum");

	jk_toggle_a: assert property (
		(clk_rise[5] && !type_sw_en_in[5] && reg_type_in[11:10] == clc_pkg::REG_JK
		&& sum_plane[5][clc_pkg::SUM_A] && sum_plane[5][clc_pkg::SUM_B] && !glb_rst
		&& !glb_pre && !reset_en_in[5] && !preset_en_in[5])
		|=> (r_reg.q[5] != $past(r_reg.q[5])))
		else $error("jk register did not toggle with both inputs high");

	sumd_oe_a: assert property (
		(clk_sel_in[13:12] == clc_pkg::CLK_SUMD) |=> oe_out[6])
		else $error("enable dropped while fourth sum clocks the cell");

endmodule
`default_nettype wire

// ===== verif/clc_pin_model.sv
`default_nettype none
// ----------------------------------------
// board side: array pins and global clock pin
// ----------------------------------------
// levels move only just after a system edge, so the array's
// synchronisers never see a pin change inside the sampling step
module clc_pin_model (
	input  wire logic                      sys_clk_in,   // system clock
	input  wire logic [clc_pkg::N_IN-1:0]  pin_req_in,   // pin levels asked for
	input  wire logic                      clk_req_in,   // global clock level asked for
	output logic      [clc_pkg::N_IN-1:0]  array_out,    // array pins
	output logic                           glb_clk_out   // global clock pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins start low, as after power-up of the board
	initial begin
		array_out   = '0;
		glb_clk_out = 1'b0;
	end
	// pins follow the request one edge later
	always @(posedge sys_clk_in) begin
		array_out   <= pin_req_in;
		glb_clk_out <= clk_req_in;
	end
endmodule
`default_nettype wire

// ===== verif/clc_array_tb.sv
`default_nettype none
module clc_array_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic                                  sys_clk_in = 1'b0;
	logic                                  rst_in     = 1'b1;
	logic [clc_pkg::N_IN-1:0]              pins       = '0;   // pin requests
	logic                                  gclk       = 1'b0; // global clock request
	logic                                  gpol       = 1'b0; // global clock polarity
	logic [clc_pkg::N_IN-1:0]              array_w;
	logic                                  glb_clk_w;
	logic [clc_pkg::N_PT*clc_pkg::N_LIT-1:0] and_pl = '0;
	logic [clc_pkg::N_CELL*clc_pkg::N_SUM*clc_pkg::N_GRP_PT-1:0] or_pl = '0;
	logic [2*clc_pkg::N_CELL-1:0]          rtype = '0, csel = '0, asel = '0, bsel = '0;
	logic [clc_pkg::N_CELL-1:0]            cpol = '0, pre_en = '0, rst_en = '0;
	logic [clc_pkg::N_CELL-1:0]            actl = '0, tsw = '0;
	logic [clc_pkg::N_CELL-1:0]            out_a, out_b, oe, fb;
	int                                    n_errors = 0, total_checks = 0, cycles = 0;

	initial forever #4 sys_clk_in = ~sys_clk_in;

	clc_pin_model i_clc_pin_model (.sys_clk_in(sys_clk_in), .pin_req_in(pins),
		.clk_req_in(gclk), .array_out(array_w), .glb_clk_out(glb_clk_w));
	clc_array i_clc_array (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .array_in(array_w),
		.glb_clk_in(glb_clk_w), .glb_clk_pol_in(gpol), .and_plane_in(and_pl),
		.or_plane_in(or_pl), .reg_type_in(rtype), .clk_sel_in(csel), .clk_pol_in(cpol),
		.preset_en_in(pre_en), .reset_en_in(rst_en), .async_ctl_in(actl),
		.type_sw_en_in(tsw), .out_a_sel_in(asel), .out_b_sel_in(bsel),
		.out_a_out(out_a), .out_b_out(out_b), .oe_out(oe), .fb_out(fb));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic final_report();
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one output bit against its expected level
	task automatic chk(input string name, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic conn(input int p, input int j);
		and_pl[p*clc_pkg::N_LIT+j] <= 1'b1;
	endtask
	task automatic route(input int c, input int s, input int t);
		or_pl[(c*clc_pkg::N_SUM+s)*clc_pkg::N_GRP_PT+t] <= 1'b1;
	endtask
	task automatic pin(input int i, input logic v);
		@(posedge sys_clk_in);
		pins[i] <= v;
	endtask
	// sync, filter and output register all fit in eight cycles
	task automatic settle();
		repeat (8) @(posedge sys_clk_in);
		#1;
	endtask
	// one slow global clock period, well under half the system rate
	task automatic pulse();
		@(posedge sys_clk_in);
		gclk <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		gclk <= 1'b0;
		settle();
	endtask
	// move the sum clock pin and let it reach the cells
	task automatic sclk(input logic v);
		pin(11, v);
		settle();
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// true and inverted literal paths, both groups, enable and feedback
	task automatic t_comb();
		pin(0, 1'b1);
		pin(4, 1'b1);
		settle();
		chk("out_a0", 1'b1, out_a[0]);
		chk("out_b0", 1'b0, out_b[0]);
		chk("out_a12", 1'b1, out_a[12]);
		chk("oe0", 1'b1, oe[0]);
		chk("fb0", 1'b1, fb[0]);
		pin(0, 1'b0);
		settle();
		chk("out_a0", 1'b0, out_a[0]);
		chk("out_b0", 1'b1, out_b[0]);
		chk("oe0", 1'b0, oe[0]);
	endtask
	// d register on the global clock
	task automatic t_dreg();
		pin(1, 1'b1);
		settle();
		chk("d_hold", 1'b0, out_a[1]);
		pulse();
		chk("d_load1", 1'b1, out_a[1]);
		chk("sw_d1", 1'b1, out_a[4]);
		pin(1, 1'b0);
		pulse();
		chk("d_load0", 1'b0, out_a[1]);
	endtask
	// toggle register counts clock edges while its input is high
	task automatic t_treg();
		pin(2, 1'b1);
		settle();
		pulse();
		chk("t_1", 1'b1, out_a[2]);
		pulse();
		chk("t_2", 1'b0, out_a[2]);
		pulse();
		chk("t_3", 1'b1, out_a[2]);
		pin(2, 1'b0);
		pulse();
		chk("t_hold", 1'b1, out_a[2]);
	endtask
	// run-time type switch: count while high, load while low
	task automatic t_type();
		pin(7, 1'b1);
		pin(1, 1'b1);
		settle();
		pulse();
		chk("sw_t1", 1'b1, out_a[4]);
		pulse();
		chk("sw_t2", 1'b0, out_a[4]);
		pin(7, 1'b0);
		settle();
		pulse();
		chk("sw_d_a", 1'b1, out_a[4]);
		pulse();
		chk("sw_d_b", 1'b1, out_a[4]);
	endtask
	// global reset and preset terms on cell 1, reset winning when both are high
	task automatic t_glb();
		pin(6, 1'b1);
		settle();
		pulse();
		chk("g_rst", 1'b0, out_a[1]);
		pin(6, 1'b0);
		pin(1, 1'b0);
		pin(5, 1'b1);
		settle();
		pulse();
		chk("g_pre", 1'b1, out_a[1]);
		pin(6, 1'b1);
		settle();
		pulse();
		chk("g_both", 1'b0, out_a[1]);
		pin(5, 1'b0);
		pin(6, 1'b0);
	endtask
	// cell preset from sum b, reset from sum c; a clocked preset waits for its edge
	task automatic t_cell();
		pin(3, 1'b1);
		settle();
		chk("c_pre", 1'b1, out_a[3]);
		chk("s_wait", 1'b0, out_a[7]);
		pulse();
		chk("s_pre", 1'b1, out_a[7]);
		chk("c_keep", 1'b1, out_a[3]);
		pin(8, 1'b1);
		settle();
		chk("c_both", 1'b0, out_a[3]);
		pin(3, 1'b0);
		pin(8, 1'b0);
		settle();
		chk("c_rel", 1'b0, out_a[3]);
	endtask
	// jk cell clocked by sum c, d cell clocked by the falling fourth sum
	task automatic t_jk();
		pin(9, 1'b1);
		settle();
		sclk(1'b1);
		chk("c_path", 1'b1, out_b[5]);
		chk("jk_set", 1'b1, out_a[5]);
		chk("neg_wait", 1'b0, out_a[6]);
		sclk(1'b0);
		chk("neg_load", 1'b1, out_a[6]);
		chk("jk_keep", 1'b1, out_a[5]);
		chk("oe_clk", 1'b1, oe[6]);
		pin(9, 1'b0);
		pin(10, 1'b1);
		settle();
		sclk(1'b1);
		chk("jk_clr", 1'b0, out_a[5]);
		sclk(1'b0);
		chk("neg_d0", 1'b0, out_a[6]);
		pin(9, 1'b1);
		settle();
		sclk(1'b1);
		chk("jk_tog", 1'b1, out_a[5]);
		sclk(1'b0);
		pin(9, 1'b0);
		pin(10, 1'b0);
		settle();
		sclk(1'b1);
		chk("jk_hold", 1'b1, out_a[5]);
		sclk(1'b0);
	endtask
	// inverted global clock: cells load when the pin falls
	task automatic t_pol();
		@(posedge sys_clk_in);
		gpol <= 1'b1;
		pin(1, 1'b1);
		settle();
		@(posedge sys_clk_in);
		gclk <= 1'b1;
		settle();
		chk("pol_hold", 1'b0, out_a[1]);
		@(posedge sys_clk_in);
		gclk <= 1'b0;
		settle();
		chk("pol_load", 1'b1, out_a[1]);
	endtask

	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	initial begin
		conn(0, 0);
		conn(1, 62);
		conn(2, 1);
		conn(3, 2);
		conn(4, 3);
		conn(5, 8);
		conn(6, 9);
		conn(7, 10);
		conn(8, 11);
		conn(61, 4);
		conn(120, 5);
		conn(121, 6);
		conn(122, 7);
		route(0, clc_pkg::SUM_A, 0);
		route(0, clc_pkg::SUM_B, 1);
		route(0, clc_pkg::SUM_D, 0);
		route(12, clc_pkg::SUM_A, 1);
		route(1, clc_pkg::SUM_A, 2);
		route(2, clc_pkg::SUM_A, 3);
		route(3, clc_pkg::SUM_B, 4);
		route(3, clc_pkg::SUM_C, 5);
		route(4, clc_pkg::SUM_A, 2);
		route(5, clc_pkg::SUM_A, 6);
		route(5, clc_pkg::SUM_B, 7);
		route(5, clc_pkg::SUM_C, 8);
		route(6, clc_pkg::SUM_A, 6);
		route(6, clc_pkg::SUM_D, 8);
		route(7, clc_pkg::SUM_B, 4);
		asel[1:0] <= clc_pkg::OUT_SUMA;
		bsel[1:0] <= clc_pkg::OUT_SUMB;
		asel[25:24] <= clc_pkg::OUT_SUMA;
		rtype[5:4] <= clc_pkg::REG_T;
		pre_en[3] <= 1'b1;
		rst_en[3] <= 1'b1;
		actl[3] <= 1'b1;
		tsw[4] <= 1'b1;
		rtype[11:10] <= clc_pkg::REG_JK;
		csel[11:10] <= clc_pkg::CLK_SUMC;
		bsel[11:10] <= clc_pkg::OUT_SUMC;
		csel[13:12] <= clc_pkg::CLK_SUMD;
		cpol[6] <= 1'b1;
		pre_en[7] <= 1'b1;
		repeat (16) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		settle();
		t_comb();
		t_dreg();
		t_treg();
		t_type();
		t_glb();
		t_cell();
		t_jk();
		t_pol();
		final_report();
	end
	// the whole run needs about five hundred cycles
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			final_report();
		end
	end
endmodule
`default_nettype wire
